// file: inc/seq_consts.vh
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
`define PHASE_W 2
`define PHASE_ONE 2'h0
`define PHASE_TWO 2'h1
`define PHASE_THREE 2'h2
`define PHASE_FOUR 2'h3
`define PHASE_N 4
`define PHASE_STEP 2'h1
`define PHASE_OUT_RESET 4'h1
`define FLAG_RESET 1'b0
`define PC_RESET 13'h0000
`define WORD_RESET 14'h0000
`endif

// file: rtl/quad_phase_fetch_execute_sequencer.v
// Overview of operation
// - Divide core clock by four into four non-overlapping phases.
// - Program counter steps once per cycle in phase one, starting fetch.
// - Word at program counter captured into fetch latch at phase four.
// - Latched word presented from phase two, executed in later phases.
// - Next fetch overlaps current execute; one cycle throughput.
// - Instructions that change program counter take two cycles.
// - Data memory operand read happens in phase two of execution.
// - Data memory destination write happens in phase four of execution.
// - On a jump, the prefetched word is dropped and the target fetched.
// - In RC mode, cycle rate output runs at a quarter of input rate.
`include "seq_consts.vh"
module quad_phase_fetch_execute_sequencer #(
   parameter PC_W = 13,
   parameter WORD_W = 14
) (
   input wire core_clk_in,
   input wire rst_n_in,
   input wire rc_mode_in,
   input wire [WORD_W-1:0] prog_data_in,
   input wire jump_req_in,
   input wire [PC_W-1:0] jump_target_in,
   output reg [PC_W-1:0] prog_addr_out,
   output reg [WORD_W-1:0] instr_out,
   output reg instr_valid_out,
   output reg [3:0] phase_out,
   output reg data_read_out,
   output reg data_write_out,
   output reg cycle_rate_out
);
   // Phase index and its next value
   reg [`PHASE_W-1:0] phase;
   reg [`PHASE_W-1:0] next_phase;
   // Program counter and its next value
   reg [PC_W-1:0] pc;
   reg [PC_W-1:0] next_pc;
   // Prefetched word and whether it may be executed
   reg [WORD_W-1:0] fetch_word;
   reg fetch_ok;
   reg next_fetch_ok;
   // Execute qualifiers
   reg exec_live;
   reg take_jump;
   reg next_valid;
   // One-hot view of the coming phase
   wire [`PHASE_N-1:0] next_hot;

   // Phase match, used by several decoders below
   function is_phase;
      input [`PHASE_W-1:0] p;
      input [`PHASE_W-1:0] code;
      begin
         is_phase = (p == code);
      end
   endfunction

   // Free-running divide by four; wraps from phase four to one
   always @*
   begin
      next_phase = phase + `PHASE_STEP;
   end

   // One decoder per phase bit, so the phases can never overlap
   genvar g;
   generate
      for (g = 0; g < `PHASE_N; g = g + 1)
      begin : g_hot
         localparam [`PHASE_W-1:0] CODE = g;
         assign next_hot[g] = is_phase(next_phase, CODE);
      end
   endgenerate

   // A jump only counts for a word that is really executing
   always @*
   begin
      exec_live = instr_valid_out;
      take_jump = exec_live && jump_req_in &&
         is_phase(phase, `PHASE_FOUR);
   end

   // Valid flag as it will stand after this edge
   always @*
   begin
      // Hand-off at phase one, so strobes must see the fresh flag
      if (is_phase(phase, `PHASE_ONE))
         next_valid = fetch_ok;
      else
         next_valid = instr_valid_out;
   end

   // Next program counter: step in phase one, load on a jump
   always @*
   begin
      next_pc = pc;
      case (phase)
         `PHASE_ONE:
         begin
            next_pc = pc + {{(PC_W-1){1'b0}}, 1'b1};
         end
         `PHASE_FOUR:
         begin
            // Target is fetched in the cycle that follows
            if (take_jump)
               next_pc = jump_target_in;
         end
         default:
         begin
            next_pc = pc;
         end
      endcase
   end

   // Prefetch usable unless a jump makes it stale
   always @*
   begin
      next_fetch_ok = fetch_ok;
      if (is_phase(phase, `PHASE_FOUR))
         next_fetch_ok = !take_jump;
   end

   // Phase index; reset parks it in phase one
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         phase <= `PHASE_ONE;
      else
         phase <= next_phase;
   end

   // Phase outputs, registered from the coming phase
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         phase_out <= `PHASE_OUT_RESET;
      else
         phase_out <= next_hot;
   end

   // Program counter register
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pc <= `PC_RESET;
      else
         pc <= next_pc;
   end

   // Address goes out as the counter steps; stands a whole cycle
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         prog_addr_out <= `PC_RESET;
      else if (is_phase(phase, `PHASE_ONE))
         prog_addr_out <= pc;
   end

   // Fetch latch; memory has three clocks to settle the word
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fetch_word <= `WORD_RESET;
      else if (is_phase(phase, `PHASE_FOUR))
         fetch_word <= prog_data_in;
   end

   // Prefetch validity; cleared so a flushed word is never run
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fetch_ok <= `FLAG_RESET;
      else
         fetch_ok <= next_fetch_ok;
   end

   // Hand the prefetched word to execute while the next is fetched
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         instr_out <= `WORD_RESET;
      else if (is_phase(phase, `PHASE_ONE))
         instr_out <= fetch_word;
   end

   // Execute flag; first cycle after reset is fetch only
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         instr_valid_out <= `FLAG_RESET;
      else
         instr_valid_out <= next_valid;
   end

   // Operand read strobe, one clock wide
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         data_read_out <= `FLAG_RESET;
      else
         data_read_out <= next_hot[`PHASE_TWO] && next_valid;
   end

   // Destination write strobe, one clock wide
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         data_write_out <= `FLAG_RESET;
      else
         data_write_out <= next_hot[`PHASE_FOUR] && next_valid;
   end

   // High in phases three and four; held low outside RC mode
   // Mode pin is taken as same-clock logic, so no synchroniser
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cycle_rate_out <= `FLAG_RESET;
      else
         cycle_rate_out <= rc_mode_in &&
            (next_hot[`PHASE_THREE] || next_hot[`PHASE_FOUR]);
   end

   // Notes for integrators:
   // Program memory must settle within three clocks of an address
   // change, since the word is captured at the end of phase four.
   // A jump request is only honoured in phase four of a valid
   // execute cycle; at any other time it is ignored on purpose,
   // which keeps a flushed word from redirecting the counter.
   // The cost of a jump is one flushed cycle, traded for a
   // single fetch port with no branch target buffer.
   // Strobes are one clock wide; data memory must act on them
   // within that clock.
   // The counter wraps silently at the top of its range.
endmodule

// file: testbench/seq_chk.sv
module seq_chk(
input wire core_clk_in, input wire rst_n_in,
input wire [13:0] prog_data_in, input wire jump_req_in,
input wire [12:0] jump_target_in, input wire [12:0] prog_addr_out,
input wire [13:0] instr_out, input wire instr_valid_out,
input wire [3:0] phase_out, input wire data_read_out,
input wire data_write_out, input wire cycle_rate_out);
timeunit 1ns; timeprecision 1ns;
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rst_n_in);
// Jump taken only at phase four of a valid cycle
wire jmp = phase_out[3] && instr_valid_out && jump_req_in;
sequence s_flush; !instr_valid_out [*4]; endsequence
AST_PH: assert property ($onehot(phase_out))
else $error("phase not one-hot");
AST_ROT: assert property (!phase_out[3] |=> phase_out == $past(phase_out) << 1)
else $error("bad phase step");
AST_PC: assert property ($changed(prog_addr_out) |-> $past(phase_out[0]))
else $error("address moved off phase one");
AST_IR: assert property (phase_out[3] && !jmp |-> ##2 instr_valid_out && instr_out == $past(prog_data_in, 2))
else $error("word not latched");
AST_INS: assert property ($changed(instr_out) |-> phase_out[1])
else $error("word changed off phase one");
AST_JMP: assert property (jmp |-> ##2 prog_addr_out == $past(jump_target_in, 2) ##0 s_flush)
else $error("jump not flushed");
AST_RD: assert property (data_read_out == (phase_out[1] && instr_valid_out))
else $error("read strobe");
AST_WR: assert property (data_write_out == (phase_out[3] && instr_valid_out))
else $error("write strobe");
AST_CR: assert property (cycle_rate_out |-> phase_out[2] || phase_out[3])
else $error("rate output");
endmodule
bind quad_phase_fetch_execute_sequencer seq_chk chk(
.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
.prog_data_in(prog_data_in), .jump_req_in(jump_req_in),
.jump_target_in(jump_target_in), .prog_addr_out(prog_addr_out),
.instr_out(instr_out), .instr_valid_out(instr_valid_out),
.phase_out(phase_out), .data_read_out(data_read_out),
.data_write_out(data_write_out), .cycle_rate_out(cycle_rate_out));

// file: testbench/prog_mem_model.sv
module prog_mem_model(
input wire [12:0] addr_in,
output wire [13:0] data_out);
timeunit 1ns; timeprecision 1ns;
// Distinct word per address so a wrong fetch shows
assign data_out = {addr_in, ~addr_in[0]} ^ 14'h15a3;
endmodule

// file: testbench/tb.sv
module tb;
timeunit 1ns; timeprecision 1ns;
reg core_clk_in = 0, rst_n_in = 0, rc_mode_in = 0, jump_req_in = 0;
reg [12:0] jump_target_in = 0, pc = 0, fa = 0;
wire [13:0] prog_data_in, instr_out;
wire [12:0] prog_addr_out;
wire [3:0] phase_out;
wire instr_valid_out, data_read_out, data_write_out, cycle_rate_out;
integer err_total = 0, compares = 0, seed = 32'h0538_a93f, ph = 0;
reg [31:0] r;
reg v = 0, rcp = 0;
reg [13:0] q[$];
quad_phase_fetch_execute_sequencer dut(.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .rc_mode_in(rc_mode_in),
   .prog_data_in(prog_data_in), .jump_req_in(jump_req_in),
   .jump_target_in(jump_target_in), .prog_addr_out(prog_addr_out),
   .instr_out(instr_out), .instr_valid_out(instr_valid_out),
   .phase_out(phase_out), .data_read_out(data_read_out),
   .data_write_out(data_write_out), .cycle_rate_out(cycle_rate_out));
prog_mem_model mem(.addr_in(prog_addr_out), .data_out(prog_data_in));
task fail(input string m);
   err_total = err_total + 1;
   $display("CHECK FAILED %0t %s", $time, m);
endtask
task report_and_stop;
   if (err_total == 0 && compares > 0)
      $display("All checks passed");
   else
      $display("Checks failed");
   $finish;
endtask
initial forever #5 core_clk_in = ~core_clk_in;
initial
begin
   repeat (4) @(posedge core_clk_in);
   #1 rst_n_in = 1;
   repeat (2000) @(posedge core_clk_in);
   report_and_stop;
end
// Watchdog well past the planned run
initial
begin
   #30000 err_total = err_total + 1;
   report_and_stop;
end
// Reference pipeline notes words, then random jumps are driven
always @(posedge core_clk_in) if (rst_n_in)
begin
   rcp = rc_mode_in;
   if (ph == 0)
   begin
      fa = pc;
      pc = pc + 1;
   end
   if (ph == 3 && v && jump_req_in)
   begin
      v = 0;
      pc = jump_target_in;
   end
   else if (ph == 3)
   begin
      q.push_back({fa, ~fa[0]} ^ 14'h15a3);
      v = 1;
   end
   ph = (ph + 1) % 4;
   #1 r = $random(seed);
   jump_req_in = r[31:30] == 2'h0;
   jump_target_in = r[12:0];
   rc_mode_in = r[20];
end
// Settled sample after every clock edge; the word is checked in phase two
always @(posedge core_clk_in)
begin
   #2 if (rst_n_in)
   begin
      compares = compares + 1;
      if (phase_out !== (4'h1 << ph)) fail("phase");
      if (prog_addr_out !== fa) fail("addr");
      if (data_read_out !== (ph == 1 && v)) fail("read");
      if (data_write_out !== (ph == 3 && v)) fail("write");
      if (cycle_rate_out !== (rcp && ph >= 2)) fail("rate");
   end
   if (phase_out === 4'h2)
   begin
      compares = compares + 1;
      if (instr_valid_out !== (q.size() != 0)) fail("valid");
      else if (q.size() != 0 && instr_out !== q.pop_front()) fail("word");
   end
end
endmodule
